// ==== cic_core_model.sv ====
// core model that answers the request line with one acknowledge strobe
`timescale 1ns/100ps

module cic_core_model (
	// clock and reset
	input  wire logic ref_clk_i,
	input  wire logic rstn_i,
	// strobe request and acknowledge
	input  wire logic go_i,
	output logic      irq_acknowledge_n_o
);
	// one low cycle per go pulse, back high after, so each fall counts once
	always_ff @(negedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_acknowledge_n_o <= 1'b1;
		end else begin
			irq_acknowledge_n_o <= !(go_i && irq_acknowledge_n_o);
		end
	end
endmodule : cic_core_model

// ==== cic_defs.svh ====
// constants of the cascaded interrupt controller
`ifndef CIC_DEFS_SVH
`define CIC_DEFS_SVH

`define CIC_NREQ        8
`define CIC_NEXT        10
`define CIC_NINT        8
`define CIC_CASC_SLOT   3'h6
`define CIC_LEVEL_MASK  8'h40
`define CIC_VBASE_M     8'h20
`define CIC_VBASE_S     8'h28
`define CIC_RST_VEC     8'h00
`define CIC_RST_PRIO    3'h0

`endif

// ==== cic_pic.sv ====
// one eight-input interrupt controller module with latch and resolver
`timescale 1ns/100ps
`include "cic_defs.svh"

module cic_pic import cic_pkg::*; #(
	parameter int         NREQ       = `CIC_NREQ,
	parameter logic [7:0] LEVEL_MASK = 8'h00
) (
	// clock and reset
	input  logic                    ref_clk_i,
	input  logic                    rstn_i,
	// programming
	input  logic                    edge_mode_i,
	input  logic [$clog2(NREQ)-1:0] prio_base_i,
	// requests and acknowledge
	input  logic [NREQ-1:0]         req_i,
	input  logic                    ack_i,
	// resolver results
	output logic [NREQ-1:0]         pending_o,
	output logic [$clog2(NREQ)-1:0] win_o,
	output logic                    int_o
);
	localparam int IW = $clog2(NREQ);

	logic [NREQ-1:0] req_prev_r;
	logic [NREQ-1:0] pend_r;
	logic [NREQ-1:0] level_sel;
	logic [NREQ-1:0] rise;
	logic [NREQ-1:0] clr;
	logic [IW-1:0]   win_nxt;

	// ==========================================
	// request latch
	assign level_sel = edge_mode_i ? LEVEL_MASK[NREQ-1:0] : {NREQ{1'b1}};
	assign rise      = req_i & ~req_prev_r;
	assign clr       = ack_i ? (NREQ'(1) << win_nxt) : '0;

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			req_prev_r <= '0;
		end else begin
			req_prev_r <= req_i;
		end
	end

	// a new edge beats the acknowledge clear of the same bit
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pend_r <= '0;
		end else begin
			pend_r <= (level_sel & req_i) |
			          (~level_sel & (rise | (pend_r & ~clr)));
		end
	end

	// ==========================================
	// priority resolver, rotated from prio_base_i
	always_comb begin
		int k;
		k = 0;
		win_nxt = '0;
		for (int i = NREQ - 1; i >= 0; i--) begin
			k = (int'(prio_base_i) + i) % NREQ;
			if (pend_r[k]) begin
				win_nxt = IW'(k);
			end
		end
	end

	assign pending_o = pend_r;
	assign win_o     = win_nxt;
	assign int_o     = |pend_r;

endmodule : cic_pic

// ==== cic_pkg.sv ====
// types shared by the cascaded interrupt controller
package cic_pkg;
	typedef logic [2:0] cic_idx_t;
	typedef logic [7:0] cic_vec_t;
	typedef logic [7:0] cic_req_t;
endpackage : cic_pkg

// ==== cic_top.sv ====
// cascaded master and slave interrupt controller with vector delivery
// Contract
// - master and slave pair, slave into master
// - ten external and eight internal sources
// - each request latches a pending bit
// - level or rising edge detection selectable
// - resolver picks winner, drives core request
// - default rank input zero first, seven last
// - software may rotate the priority order
// - four low external pins accept cascaded controllers as plain requests in master level mode
`timescale 1ns/100ps
`include "cic_defs.svh"

module cic_top import cic_pkg::*; (
	// clock and reset
	input  logic                  ref_clk_i,
	input  logic                  rstn_i,
	// request sources
	input  logic [`CIC_NEXT-1:0]  external_irq_pins_i,
	input  logic [`CIC_NINT-1:0]  internal_irq_i,
	// programming levels
	input  logic                  m_edge_mode_i,
	input  logic                  s_edge_mode_i,
	input  cic_idx_t              m_prio_base_i,
	input  cic_idx_t              s_prio_base_i,
	// processor side
	input  logic                  irq_acknowledge_n_i,
	output logic                  irq_o,
	output cic_vec_t              vector_o,
	output logic                  vector_valid_o
);
	cic_req_t m_req;
	cic_req_t s_req;
	cic_req_t m_pend;
	cic_req_t s_pend;
	cic_idx_t m_win;
	cic_idx_t s_win;
	logic     m_int;
	logic     s_int;
	logic     ack_prev_r;
	logic     ack_fall;
	logic     m_ack;
	logic     s_ack;
	logic     irq_r;
	logic     vvalid_r;
	cic_vec_t vector_r;

	// ==========================================
	// source mapping
	// low pins go straight to the master so outside controllers can cascade there while it is in level mode
	assign m_req[3:0] = external_irq_pins_i[3:0];
	assign m_req[4]   = external_irq_pins_i[4];
	assign m_req[5]   = external_irq_pins_i[5];
	assign m_req[6]   = s_int;
	assign m_req[7]   = external_irq_pins_i[6];
	// slave pins 0..2 are shared by OR; a source cannot be told apart from its twin
	assign s_req      = internal_irq_i |
	                    {5'h00, external_irq_pins_i[9:7]};

	// ==========================================
	// controller modules
	cic_pic #(
		.NREQ       (`CIC_NREQ),
		.LEVEL_MASK (`CIC_LEVEL_MASK)
	) u_master (
		.ref_clk_i   (ref_clk_i),
		.rstn_i      (rstn_i),
		.edge_mode_i (m_edge_mode_i),
		.prio_base_i (m_prio_base_i),
		.req_i       (m_req),
		.ack_i       (m_ack),
		.pending_o   (m_pend),
		.win_o       (m_win),
		.int_o       (m_int)
	);

	cic_pic #(
		.NREQ       (`CIC_NREQ),
		.LEVEL_MASK (8'h00)
	) u_slave (
		.ref_clk_i   (ref_clk_i),
		.rstn_i      (rstn_i),
		.edge_mode_i (s_edge_mode_i),
		.prio_base_i (s_prio_base_i),
		.req_i       (s_req),
		.ack_i       (s_ack),
		.pending_o   (s_pend),
		.win_o       (s_win),
		.int_o       (s_int)
	);

	// ==========================================
	// acknowledge handling
	// acknowledge arrives already decoded by outside logic from bus status
	assign ack_fall = ack_prev_r & ~irq_acknowledge_n_i;
	assign m_ack    = ack_fall & m_int;
	assign s_ack    = m_ack & (m_win == `CIC_CASC_SLOT) & s_int;

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ack_prev_r <= 1'b1;
		end else begin
			ack_prev_r <= irq_acknowledge_n_i;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= m_int;
		end
	end

	// vector is held until the next acknowledge; an empty acknowledge gives no pulse
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			vector_r <= `CIC_RST_VEC;
			vvalid_r <= 1'b0;
		end else begin
			vvalid_r <= m_ack;
			if (s_ack) begin
				vector_r <= `CIC_VBASE_S + {5'h00, s_win};
			end else if (m_ack) begin
				vector_r <= `CIC_VBASE_M + {5'h00, m_win};
			end
		end
	end

	assign irq_o          = irq_r;
	assign vector_o       = vector_r;
	assign vector_valid_o = vvalid_r;

	// ==========================================
	// checks
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);

	sequence ack_seen;
		ack_fall && m_int;
	endsequence

	sequence pulse_once;
		vector_valid_o ##1 !vector_valid_o;
	endsequence

	chk_ack_pulse: assert property (ack_seen |=> pulse_once)
		else $error("acknowledge did not give a single valid pulse");

	chk_no_spurious: assert property (!(ack_fall && m_int) |=> !vector_valid_o)
		else $error("valid pulse without acknowledge");

	chk_master_vec: assert property (
		ack_seen and (m_win != `CIC_CASC_SLOT) |=>
		vector_o == `CIC_VBASE_M + {5'h00, $past(m_win)})
		else $error("master vector wrong");

	chk_cascade_vec: assert property (
		ack_seen and (m_win == `CIC_CASC_SLOT) and s_int |=>
		vector_o == `CIC_VBASE_S + {5'h00, $past(s_win)})
		else $error("slave vector wrong");

	chk_irq_follow: assert property (m_pend == 8'h00 |=> !irq_o)
		else $error("core request without pending input");

	chk_default_rank: assert property (
		m_prio_base_i == `CIC_RST_PRIO && m_pend[0] |-> m_win == 3'h0)
		else $error("input zero not ranked first");

	chk_lowest_rank: assert property (
		m_prio_base_i == `CIC_RST_PRIO && m_pend == 8'h80 |-> m_win == 3'h7)
		else $error("input seven not reached");

	chk_rotate_top: assert property (m_pend[m_prio_base_i] |-> m_win == m_prio_base_i)
		else $error("rotated base not ranked first");

	chk_level_pin: assert property (
		!m_edge_mode_i && external_irq_pins_i[3] |=> m_pend[3])
		else $error("cascade pin level not latched");

	chk_edge_latch: assert property (
		m_edge_mode_i && $rose(external_irq_pins_i[0]) ##1
		m_edge_mode_i |-> m_pend[0])
		else $error("rising edge not latched");

	chk_edge_clear: assert property (
		m_edge_mode_i && ack_fall && m_int && m_win == 3'h0 && !external_irq_pins_i[0] ##1
		m_edge_mode_i && !$rose(external_irq_pins_i[0]) |-> !m_pend[0])
		else $error("edge pending not cleared on acknowledge");

	// ==========================================
	// slave side, hold and core request raise checks
	// the slave is watched directly so a fault there cannot hide behind slot six
	sequence slave_taken;
		ack_fall && m_int && (m_win == `CIC_CASC_SLOT) && s_int;
	endsequence

	chk_vec_hold: assert property (!(ack_fall && m_int) |=> $stable(vector_o))
		else $error("vector changed without acknowledge");

	chk_irq_raise: assert property (m_pend != 8'h00 |=> irq_o)
		else $error("pending input gave no core request");

	chk_slave_level: assert property (!s_edge_mode_i |=> s_pend == $past(s_req))
		else $error("slave level request not latched");

	chk_slave_rotate: assert property (
		s_pend[s_prio_base_i] |-> s_win == s_prio_base_i)
		else $error("slave rotated base not ranked first");

	chk_slave_edge: assert property (
		s_edge_mode_i && !s_ack |=>
		s_pend == ($past(s_pend) | ($past(s_req) & ~$past(s_req, 2))))
		else $error("slave rising edge not latched");

	chk_slave_clear: assert property (
		slave_taken and (s_edge_mode_i && !s_req[s_win]) |=> !s_pend[$past(s_win)])
		else $error("slave edge pending not cleared on acknowledge");

endmodule : cic_top

// ==== tb_top.sv ====
// self-checking testbench of the cascaded interrupt controller
`timescale 1ns/100ps
`include "cic_defs.svh"

module tb_top import cic_pkg::*; ;
	// ===========================================
	// signals
	logic                 clk = 1'b0;
	logic                 rstn = 1'b0;
	logic [`CIC_NEXT-1:0] ext = '0;
	logic [`CIC_NINT-1:0] intr = '0;
	logic                 me = 1'b0;
	cic_idx_t             mb = 3'h0;
	logic                 se = 1'b0;
	cic_idx_t             sb = 3'h0;
	logic                 go = 1'b0;
	logic                 ack_n;
	logic                 irq;
	cic_vec_t             vec;
	logic                 vv;
	int                   fail_count = 0;
	int                   total_checks = 0;
	int                   cyc = 0;
	logic                 seen;
	cic_vec_t             v;

	always #25 clk = ~clk;

	cic_top dut (.ref_clk_i(clk), .rstn_i(rstn), .external_irq_pins_i(ext),
		.internal_irq_i(intr), .m_edge_mode_i(me), .s_edge_mode_i(se),
		.m_prio_base_i(mb), .s_prio_base_i(sb), .irq_acknowledge_n_i(ack_n),
		.irq_o(irq), .vector_o(vec), .vector_valid_o(vv));

	cic_core_model core (.ref_clk_i(clk), .rstn_i(rstn), .go_i(go),
		.irq_acknowledge_n_o(ack_n));

	// ===========================================
	// helpers
	task automatic chk(input logic [7:0] e, input logic [7:0] a);
		total_checks++;
		if (e !== a) begin
			$display("[ERR] t=%0t exp=%h got=%h", $time, e, a);
			fail_count++;
		end
	endtask : chk

	task automatic take_ack();
		seen = 1'b0;
		@(negedge clk) go <= 1'b1;
		@(negedge clk) go <= 1'b0;
		repeat (5) begin
			@(posedge clk) #1;
			if (vv === 1'b1) begin
				seen = 1'b1;
				v = vec;
			end
		end
	endtask : take_ack

	// level requests held, one acknowledge, inputs dropped afterwards
	task automatic lvl(input logic [9:0] e, input logic [7:0] i, input cic_vec_t x);
		@(negedge clk) ext <= e;
		intr <= i;
		repeat (3) @(negedge clk);
		take_ack();
		chk(8'h01, {7'h00, seen});
		chk(x, v);
		@(negedge clk) ext <= '0;
		intr <= '0;
	endtask : lvl

	// ===========================================
	// scenarios
	task automatic t_edge();
		@(negedge clk) me <= 1'b1;
		ext[0] <= 1'b1;
		@(negedge clk) ext[0] <= 1'b0;
		repeat (2) @(negedge clk);
		chk(8'h01, {7'h00, irq});
		take_ack();
		chk(8'h20, v);
		chk(8'h00, {7'h00, irq});
		@(negedge clk) me <= 1'b0;
	endtask : t_edge

	task automatic t_prio();
		lvl(10'h041, 8'h00, 8'h20);
		@(negedge clk) mb <= 3'h7;
		lvl(10'h041, 8'h00, 8'h27);
		@(negedge clk) mb <= 3'h0;
	endtask : t_prio

	task automatic t_slave();
		lvl(10'h000, 8'h02, 8'h29);
		lvl(10'h200, 8'h00, 8'h2a);
		lvl(10'h000, 8'h80, 8'h2f);
	endtask : t_slave

	// slave edge latch with its own clear, then a rotated slave rank
	task automatic t_sside();
		@(negedge clk) se <= 1'b1;
		intr[3] <= 1'b1;
		@(negedge clk) intr[3] <= 1'b0;
		repeat (3) @(negedge clk);
		chk(8'h01, {7'h00, irq});
		take_ack();
		chk(8'h2b, v);
		chk(8'h00, {7'h00, irq});
		@(negedge clk) se <= 1'b0;
		sb <= 3'h4;
		lvl(10'h000, 8'h11, 8'h2c);
		@(negedge clk) sb <= 3'h0;
		lvl(10'h000, 8'h11, 8'h28);
	endtask : t_sside

	// cascaded controllers appear as plain requests on the low pins
	task automatic t_casc();
		for (int k = 0; k < 4; k++) begin
			lvl(10'h001 << k, 8'h00, 8'h20 + 8'(k));
		end
	endtask : t_casc

	task automatic t_refuse();
		repeat (3) @(negedge clk);
		chk(8'h00, {7'h00, irq});
		take_ack();
		chk(8'h00, {7'h00, seen});
		chk(8'h23, vec);
	endtask : t_refuse

	// ===========================================
	// run control
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : wrap_up

	// whole run is under two hundred cycles; the ceiling leaves ample slack
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			wrap_up();
		end
	end

	initial begin
		repeat (16) @(posedge clk);
		@(negedge clk) rstn <= 1'b1;
		repeat (2) @(negedge clk);
		t_edge();
		t_prio();
		t_slave();
		t_sside();
		t_casc();
		t_refuse();
		wrap_up();
	end
endmodule : tb_top
